/* shared/stm_map.svh */
/*
 Register offsets, field positions, reset values and encodings of the timer.
 Assumes it is included by bare name wherever these names are needed.
*/
`ifndef STM_MAP_SVH
`define STM_MAP_SVH
// ====================================================================
// Register offsets (byte registers on a plain port)
`define STM_OFF_CNT_LO   3'h0
`define STM_OFF_CNT_HI   3'h1
`define STM_OFF_CMPA_LO  3'h2
`define STM_OFF_CMPA_HI  3'h3
`define STM_OFF_CTRL0    3'h4
`define STM_OFF_CTRL1    3'h5
`define STM_OFF_FLAGS    3'h6
// ====================================================================
// Control zero fields
`define STM_C0_PAUSE     7
`define STM_C0_CKS_HI    6
`define STM_C0_CKS_LO    4
`define STM_C0_ON        3
`define STM_C0_RP_HI     2
`define STM_C0_RP_LO     0
// ====================================================================
// Control one fields
`define STM_C1_MODE_HI   7
`define STM_C1_MODE_LO   6
`define STM_C1_IO_HI     5
`define STM_C1_IO_LO     4
`define STM_C1_OC        3
`define STM_C1_POL       2
`define STM_C1_DPX       1
`define STM_C1_CCLR      0
// ====================================================================
// Flag register fields (write one to clear)
`define STM_FL_A         0
`define STM_FL_P         1
`define STM_FL_C         2
// ====================================================================
// Reset values and constants
`define STM_RST_BYTE     8'h00
`define STM_RST_CNT      10'h000
`define STM_CNT_MAX      10'h3ff
`define STM_CNT_ONE      10'h001
`define STM_RP_ZERO      3'h0
`define STM_DIV4_LAST    2'h3
`define STM_DIV16_LAST   4'hf
`define STM_DIV64_LAST   6'h3f
`define STM_RD_ZERO      8'h00
`define STM_RP_SHIFT     7
`define STM_P_ONES       7'h7f
`endif

/* shared/stm_pkg.sv */
/*
 Types of the standard timer: modes, clock sources, output functions.
 Assumes the map header is present alongside for numeric constants.
*/
package stm_pkg;
   // ====================================================================
   // Operating modes
   typedef enum logic [1:0]
   {
      STM_MODE_CMP   = 2'h0,
      STM_MODE_CAP   = 2'h1,
      STM_MODE_PWM   = 2'h2,
      STM_MODE_TMR   = 2'h3
   } stm_mode_e;
   // Clock sources
   typedef enum logic [2:0]
   {
      STM_CK_SYS4    = 3'h0,
      STM_CK_SYS     = 3'h1,
      STM_CK_H16     = 3'h2,
      STM_CK_H64     = 3'h3,
      STM_CK_TBC     = 3'h4,
      STM_CK_UNDEF   = 3'h5,
      STM_CK_EXT_R   = 3'h6,
      STM_CK_EXT_F   = 3'h7
   } stm_clk_e;
   // Output function codes
   typedef enum logic [1:0]
   {
      STM_IO_0       = 2'h0,
      STM_IO_1       = 2'h1,
      STM_IO_2       = 2'h2,
      STM_IO_3       = 2'h3
   } stm_io_e;
endpackage

/* design/stm_timer.sv */
/*
 Ten-bit standard timer with comparators A and P, byte registers on a plain
 port, three output pins and an external count pin.
 Assumes every input is synchronous to core_clk_i, and that the high clock
 and time-base ticks arrive as one-cycle enables from the clock tree.
*/
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "stm_map.svh"

module stm_timer
   import stm_pkg::*;
(
   input  wire logic       core_clk_i,          // System clock, 200 MHz
   input  wire logic       reset_n_i,           // Synchronous reset, active low
   input  wire logic [2:0] addr_i,              // Register address
   input  wire logic [7:0] wdata_i,             // Write data
   input  wire logic       wr_i,                // Write strobe
   input  wire logic       rd_i,                // Read strobe
   output logic      [7:0] rdata_o,             // Read data, cycle after strobe
   input  wire logic       fh_tick_i,           // High clock tick enable
   input  wire logic       ftbc_tick_i,         // Time-base clock tick enable
   input  wire logic       external_count_pin_i, // External count pin level
   input  wire logic       capture_in_i,        // Capture input level on pin
   output logic            timer_output_pin_zero_o, // Output pin zero
   output logic            timer_output_pin_one_o,  // Output pin one
   output logic            timer_output_pin_two_o,  // Output pin two
   output logic            pin_drive_o,         // High while pins are driven
   output logic            compare_a_flag_o,    // Compare A flag
   output logic            compare_p_flag_o,    // Compare P flag
   output logic            capture_flag_o,      // Capture event flag
   output logic            counter_on_o         // Module on (powered)
);

   // ====================================================================
   // Registers
   logic [7:0] ctrl0_reg;                       // Control zero
   logic [7:0] ctrl1_reg;                       // Control one
   logic [9:0] compare_a_value_reg;             // Compare A value
   logic [9:0] count_reg;                       // Running counter
   logic [9:0] capture_reg;                     // Captured count
   logic       on_d_reg;                        // Previous on bit
   logic       ext_d_reg;                       // Previous external pin
   logic       cap_d_reg;                       // Previous capture pin
   logic [1:0] div4_reg;                        // System divider by four
   logic [3:0] div16_reg;                       // High clock divider by 16
   logic [5:0] div64_reg;                       // High clock divider by 64
   logic       pin_reg;                         // Raw compare-mode pin level
   logic       pulse_reg;                       // Single pulse active
   logic       out_next;                        // Pin value before fan-out

   // Field views
   logic       counter_pause;
   logic [2:0] timer_clock_select;
   logic       counter_on;
   logic [2:0] compare_p_value;
   stm_mode_e  operating_mode_select;
   stm_io_e    output_function_select;
   logic       output_initial_level;
   logic       output_invert;
   logic       period_duty_swap;
   logic       counter_clear_select;

   assign counter_pause          = ctrl0_reg[`STM_C0_PAUSE];
   assign timer_clock_select     = ctrl0_reg[`STM_C0_CKS_HI:`STM_C0_CKS_LO];
   assign counter_on             = ctrl0_reg[`STM_C0_ON];
   assign compare_p_value        = ctrl0_reg[`STM_C0_RP_HI:`STM_C0_RP_LO];
   assign operating_mode_select  = stm_mode_e'(ctrl1_reg[`STM_C1_MODE_HI:`STM_C1_MODE_LO]);
   assign output_function_select = stm_io_e'(ctrl1_reg[`STM_C1_IO_HI:`STM_C1_IO_LO]);
   assign output_initial_level   = ctrl1_reg[`STM_C1_OC];
   assign output_invert          = ctrl1_reg[`STM_C1_POL];
   assign period_duty_swap       = ctrl1_reg[`STM_C1_DPX];
   assign counter_clear_select   = ctrl1_reg[`STM_C1_CCLR];

   // ====================================================================
   // Bus decode
   logic wr_ctrl0;                              // Write to control zero
   logic on_rise;                               // On bit goes 0 to 1
   logic single_mode;                           // Single pulse selected
   logic ext_edge;                              // Active edge on the count pin
   logic pulse_end;                             // Single pulse ends on A match
   assign wr_ctrl0    = wr_i && (addr_i == `STM_OFF_CTRL0);
   assign on_rise     = counter_on && !on_d_reg;
   assign single_mode = (operating_mode_select == STM_MODE_PWM) && (output_function_select == STM_IO_3);

   // Control zero; in single pulse mode an external active edge sets on
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         ctrl0_reg <= `STM_RST_BYTE;
      else if (wr_ctrl0)
         ctrl0_reg <= wdata_i;
      else if (single_mode && !counter_on && ext_edge)
         ctrl0_reg[`STM_C0_ON] <= 1'b1;
      else if (single_mode && pulse_end)
         ctrl0_reg[`STM_C0_ON] <= 1'b0;
   end

   // reset zero
   // Control one and compare A
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         ctrl1_reg           <= `STM_RST_BYTE;
         compare_a_value_reg <= `STM_RST_CNT;
      end
      else if (wr_i)
      begin
         unique case (addr_i)
            `STM_OFF_CTRL1:   ctrl1_reg <= wdata_i;
            `STM_OFF_CMPA_LO: compare_a_value_reg[7:0] <= wdata_i;
            `STM_OFF_CMPA_HI: compare_a_value_reg[9:8] <= wdata_i[1:0];
            default:          ;                  // Other offsets ignored here
         endcase
      end
   end

   // Read data stands one cycle after the read strobe only
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         rdata_o <= `STM_RD_ZERO;
      else if (rd_i)
      begin
         unique case (addr_i)
            `STM_OFF_CNT_LO:  rdata_o <= count_reg[7:0];
            `STM_OFF_CNT_HI:  rdata_o <= {6'h00, count_reg[9:8]};
            `STM_OFF_CMPA_LO: rdata_o <= compare_a_value_reg[7:0];
            `STM_OFF_CMPA_HI: rdata_o <= {6'h00, compare_a_value_reg[9:8]};
            `STM_OFF_CTRL0:   rdata_o <= ctrl0_reg;
            `STM_OFF_CTRL1:   rdata_o <= ctrl1_reg;
            `STM_OFF_FLAGS:   rdata_o <= {5'h00, capture_flag_o, compare_p_flag_o, compare_a_flag_o};
            default:          rdata_o <= capture_reg[7:0]; // Capture low byte
         endcase
      end
      else
         rdata_o <= `STM_RD_ZERO;
   end

   // ====================================================================
   // Timer clock selection
   logic tick;                                  // Selected timer clock edge
   assign ext_edge = (timer_clock_select == STM_CK_EXT_F) ? (ext_d_reg && !external_count_pin_i)
                                                          : (!ext_d_reg && external_count_pin_i);

   // Prescalers free-run so the source can change without a glitch
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         div4_reg  <= 2'h0;
         div16_reg <= 4'h0;
         div64_reg <= 6'h0;
         ext_d_reg <= 1'b0;
         cap_d_reg <= 1'b0;
         on_d_reg  <= 1'b0;
      end
      else
      begin
         div4_reg  <= div4_reg + 2'h1;
         div16_reg <= fh_tick_i ? div16_reg + 4'h1 : div16_reg;
         div64_reg <= fh_tick_i ? div64_reg + 6'h1 : div64_reg;
         ext_d_reg <= external_count_pin_i;
         cap_d_reg <= capture_in_i;
         on_d_reg  <= counter_on;
      end
   end

   always_comb
   begin
      unique case (stm_clk_e'(timer_clock_select))
         STM_CK_SYS4:  tick = (div4_reg == `STM_DIV4_LAST);
         STM_CK_SYS:   tick = 1'b1;
         STM_CK_H16:   tick = fh_tick_i && (div16_reg == `STM_DIV16_LAST);
         STM_CK_H64:   tick = fh_tick_i && (div64_reg == `STM_DIV64_LAST);
         STM_CK_TBC:   tick = ftbc_tick_i;
         STM_CK_UNDEF: tick = 1'b0;             // Forbidden code: counter stalls
         STM_CK_EXT_R: tick = ext_edge;
         STM_CK_EXT_F: tick = ext_edge;
      endcase
   end

   // ====================================================================
   // Comparators
   logic match_a;                               // Counter equals compare A
   logic match_p;                               // Counter at 128 * P - 1, P nonzero
   logic overflow;                              // Counter at maximum
   logic run;                                   // Counting this cycle
   logic clear_now;                             // Counter clears on this tick
   logic cmp_like;                              // Compare or timer mode
   assign run      = counter_on && !counter_pause && tick;
   assign match_a  = run && (count_reg == compare_a_value_reg);
   assign match_p  = run && (compare_p_value != `STM_RP_ZERO)
                     && (count_reg == {compare_p_value - 3'h1, `STM_P_ONES});
   // Matching the last count below P keeps the period at 128 * P clocks
   assign overflow = run && (count_reg == `STM_CNT_MAX);
   assign cmp_like = (operating_mode_select == STM_MODE_CMP) || (operating_mode_select == STM_MODE_TMR);
   assign pulse_end = single_mode && match_a;

   always_comb
   begin
      if (cmp_like)
         clear_now = counter_clear_select ? match_a : (match_p || overflow);
      else if (operating_mode_select == STM_MODE_PWM)
         clear_now = period_duty_swap ? match_a : (match_p || overflow); // period comparator
      else
         clear_now = overflow;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         count_reg <= `STM_RST_CNT;
      else if (on_rise)
         count_reg <= `STM_RST_CNT;
      else if (clear_now)
         count_reg <= `STM_RST_CNT;
      else if (run)
         count_reg <= count_reg + `STM_CNT_ONE;
   end

   // ====================================================================
   // Flags: sticky, write one to clear, a new event wins over the clear
   logic clr_a;
   logic clr_p;
   logic clr_c;
   logic cap_event;
   assign clr_a = wr_i && (addr_i == `STM_OFF_FLAGS) && wdata_i[`STM_FL_A];
   assign clr_p = wr_i && (addr_i == `STM_OFF_FLAGS) && wdata_i[`STM_FL_P];
   assign clr_c = wr_i && (addr_i == `STM_OFF_FLAGS) && wdata_i[`STM_FL_C];

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         compare_a_flag_o <= 1'b0;
         compare_p_flag_o <= 1'b0;
         capture_flag_o   <= 1'b0;
      end
      else
      begin
         compare_a_flag_o <= match_a || (compare_a_flag_o && !clr_a);
         compare_p_flag_o <= (match_p && !(cmp_like && counter_clear_select))
                             || (compare_p_flag_o && !clr_p);
         capture_flag_o   <= cap_event || (capture_flag_o && !clr_c);
      end
   end

   always_comb
   begin
      unique case (output_function_select)
         STM_IO_0: cap_event = !cap_d_reg && capture_in_i;
         STM_IO_1: cap_event = cap_d_reg && !capture_in_i;
         STM_IO_2: cap_event = cap_d_reg != capture_in_i;
         STM_IO_3: cap_event = 1'b0;
      endcase
      cap_event = cap_event && counter_on && (operating_mode_select == STM_MODE_CAP);
   end

   // Captured count, read back at offset seven
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         capture_reg <= `STM_RST_CNT;
      else if (cap_event)
         capture_reg <= count_reg;
   end

   // ====================================================================
   // Output pin logic
   // initial level
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         pin_reg <= 1'b0;
      else if (on_rise)
         pin_reg <= output_initial_level;
      else if (match_a && operating_mode_select == STM_MODE_CMP)
      begin
         unique case (output_function_select)
            STM_IO_0: pin_reg <= pin_reg;
            STM_IO_1: pin_reg <= 1'b0;
            STM_IO_2: pin_reg <= 1'b1;
            STM_IO_3: pin_reg <= !pin_reg;
         endcase
      end
   end

   // Single pulse is active from the on rise until on falls
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         pulse_reg <= 1'b0;
      else if (on_rise)
         pulse_reg <= 1'b1;
      else if (!counter_on || pulse_end)
         pulse_reg <= 1'b0;
   end

   // PWM active window: duty compare against the low count
   logic [9:0] period_cnt;                      // Period length in counts
   logic [9:0] duty_cnt;                        // Duty length in counts
   logic [10:0] period_p;                       // Compare P period
   logic       pwm_active;
   assign period_p   = (compare_p_value == `STM_RP_ZERO) ? 11'h400
                       : {1'b0, compare_p_value, 7'h00};
   assign period_cnt = period_duty_swap ? compare_a_value_reg : period_p[9:0];
   assign duty_cnt   = period_duty_swap ? period_p[9:0] : compare_a_value_reg;
   assign pwm_active = period_duty_swap
                       ? ((period_p >= {1'b0, period_cnt}) || (count_reg < duty_cnt))
                       : (({1'b0, duty_cnt} >= period_p) || (count_reg < duty_cnt));

   always_comb
   begin
      out_next = pin_reg;
      if (operating_mode_select == STM_MODE_PWM)
      begin
         unique case (output_function_select)
            STM_IO_0: out_next = !output_initial_level;
            STM_IO_1: out_next = output_initial_level;
            STM_IO_2: out_next = (counter_on && pwm_active) ? output_initial_level : !output_initial_level;
            STM_IO_3: out_next = pulse_reg ? output_initial_level : !output_initial_level;
         endcase
      end
      if (operating_mode_select != STM_MODE_TMR)
         out_next = out_next ^ output_invert;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         timer_output_pin_zero_o <= 1'b0;
         timer_output_pin_one_o  <= 1'b0;
         timer_output_pin_two_o  <= 1'b0;
         pin_drive_o             <= 1'b0;
         counter_on_o            <= 1'b0;
      end
      else
      begin
         timer_output_pin_zero_o <= out_next;
         timer_output_pin_one_o  <= out_next;
         timer_output_pin_two_o  <= out_next;
         pin_drive_o             <= (operating_mode_select == STM_MODE_CMP)
                                    || (operating_mode_select == STM_MODE_PWM);
         counter_on_o            <= counter_on;
      end
   end

   // ====================================================================
   // Assertions
   property p_flag_a;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      match_a |=> compare_a_flag_o;
   endproperty
   a_flag_a: assert property (p_flag_a) else $error("compare A flag missed");

   property p_no_p_flag;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (cmp_like && counter_clear_select && !compare_p_flag_o) |=> !compare_p_flag_o;
   endproperty
   a_no_p_flag: assert property (p_no_p_flag) else $error("P flag raised under clear on A");

   property p_on_clear;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      on_rise |=> (count_reg == `STM_RST_CNT);
   endproperty
   a_on_clear: assert property (p_on_clear) else $error("on rise did not clear counter");

   property p_pause;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (counter_pause && !on_rise && !wr_ctrl0) |=> $stable(count_reg);
   endproperty
   a_pause: assert property (p_pause) else $error("counter moved while paused");

   property p_off_hold;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (!counter_on && !on_rise) |=> $stable(count_reg);
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("counter moved while off");

   property p_init;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      on_rise |=> (pin_reg == $past(output_initial_level));
   endproperty
   a_init: assert property (p_init) else $error("initial level not restored");

   property p_count;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (run && !clear_now && !on_rise) |=> (count_reg == $past(count_reg) + `STM_CNT_ONE);
   endproperty
   a_count: assert property (p_count) else $error("counter did not step by one");

   property p_hi_zero;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `STM_OFF_CNT_HI) |=> (rdata_o[7:2] == 6'h00);
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("unused high bits not zero");

endmodule

/* dv/stm_pin_model.sv */
/*
 Outside source for the timer's input pins: bursts of one-cycle high pulses.
 Assumes go_i is a one-cycle request, made only while the model is idle.
*/
`timescale 1ns/1ps
module stm_pin_model
(
   input  wire logic       clk_i,   // Bench clock
   input  wire logic       go_i,    // Start a burst
   input  wire logic [7:0] count_i, // Pulses in burst
   input  wire logic       slow_i,  // Wide gaps
   output logic            pin_o,   // Pin level
   output logic            busy_o   // Burst running
);
   int   left  = 0;    // Pulses still due
   int   gap   = 0;    // Low cycles before next pulse
   logic pin_q = 1'b0; // Pin level, idle low
   // ==========================================
   // Burst engine; the gap keeps edges apart
   always @(posedge clk_i)
   begin
      if (go_i)
         left <= count_i;
      else if (pin_q)
         pin_q <= 1'b0;
      else if (gap != 0)
         gap <= gap - 1;
      else if (left != 0)
      begin
         pin_q <= 1'b1;
         left  <= left - 1;
         gap   <= slow_i ? 9 : 2;
      end
   end
   assign pin_o  = pin_q;
   assign busy_o = (left != 0) || pin_q;
endmodule

/* dv/test_standard_timer_control_regs.sv */
/*
 Self-checking bench of the timer: register port, counting, pins.
 Assumes the design files and the pin model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("MISMATCH t=%0t %s", $time, msg); end end
module test_standard_timer_control_regs;
   logic       core_clk = 0;         // 200 MHz clock
   logic       rst_n = 0;            // Reset, active low
   logic [2:0] addr = 0;             // Register address
   logic [7:0] wdata = 0;            // Write data
   logic       wr = 0;               // Write strobe
   logic       rd = 0;               // Read strobe
   logic       go = 0;               // Model request
   logic       slow = 0;             // Model pacing
   logic [7:0] k = 0;                // Pulse count
   logic [2:0] cks;                  // Clock select code
   logic       pin, busy, e;         // Model outputs, expected level
   logic [7:0] rdata;                // Read data
   logic       p0, p1, p2, drv, fa, fp, fc, on_q; // Design outputs
   logic       rd_d = 0;             // Read issued last cycle
   logic [7:0] exp_q[$];             // Expected read data
   logic [9:0] v;                    // Random value
   int         miscompares = 0, checked = 0, n, i;
   always #2.5 core_clk = ~core_clk;
   stm_pin_model model (.clk_i(core_clk), .go_i(go), .count_i(k), .slow_i(slow), .pin_o(pin), .busy_o(busy));
   stm_timer uut (.core_clk_i(core_clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .fh_tick_i(pin), .ftbc_tick_i(pin), .external_count_pin_i(pin),
      .capture_in_i(pin), .timer_output_pin_zero_o(p0), .timer_output_pin_one_o(p1),
      .timer_output_pin_two_o(p2), .pin_drive_o(drv), .compare_a_flag_o(fa), .compare_p_flag_o(fp),
      .capture_flag_o(fc), .counter_on_o(on_q));
   // ==========================================
   // Bus tasks and bounded waits
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] x);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge core_clk);
      rd <= 1'b0;
   endtask
   // Waits on A flag (0), P flag (1) or model idle (2)
   task automatic wait_hi(input int w, input int lim);
      for (i = 0; i < lim && !(w == 0 ? fa === 1'b1 : w == 1 ? fp === 1'b1 : busy === 1'b0); i++)
         @(posedge core_clk);
      if (i == lim)
      begin
         miscompares++;
         $display("MISMATCH t=%0t wait ran out", $time);
         complete_run();
      end
   endtask
   // One burst of pulses from the pin model, then settle
   task automatic burst(input logic [7:0] cnt, input logic s);
      @(posedge core_clk);
      k <= cnt;
      slow <= s;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      wait_hi(2, 400);
      repeat (4) @(posedge core_clk);
   endtask
   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // Read monitor: oldest note against data one cycle after the strobe
   always @(posedge core_clk)
   begin
      if (rd_d)
         `CHK(rdata, exp_q.pop_front(), "read data")
      rd_d <= rd;
   end
   initial
   begin
      #400000;
      miscompares++;
      complete_run();
   end
   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h2488));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      for (n = 0; n < 8; n++)
         rd_reg(n[2:0], 8'h00);
      v = 10'($urandom);
      wr_reg(3'h2, v[7:0]);
      wr_reg(3'h3, 8'hfc | 8'(v[9:8]));
      wr_reg(3'h0, 8'h5a);
      rd_reg(3'h2, v[7:0]);
      rd_reg(3'h3, {6'h00, v[9:8]});
      $display("test registers done");
      wr_reg(3'h4, 8'h98);
      rd_reg(3'h0, 8'h00);
      n = $urandom_range(400, 200);
      wr_reg(3'h4, 8'h18);
      repeat (n) @(posedge core_clk);
      wr_reg(3'h4, 8'h98);
      v = 10'(n + 2);
      repeat (10) @(posedge core_clk);
      rd_reg(3'h0, v[7:0]);
      rd_reg(3'h1, {6'h00, v[9:8]});
      wr_reg(3'h4, 8'h90);
      rd_reg(3'h0, v[7:0]);
      wr_reg(3'h4, 8'h98);
      rd_reg(3'h0, 8'h00);
      $display("test counting done");
      for (n = 0; n < 4; n++)
      begin
         cks = n == 0 ? 3'h4 : n == 1 ? 3'h6 : n == 2 ? 3'h7 : 3'h5;
         wr_reg(3'h4, {1'b1, cks, 4'h0});
         wr_reg(3'h4, {1'b0, cks, 4'h8});
         burst(8'($urandom_range(20, 3)), n[0]);
         rd_reg(3'h0, cks == 3'h5 ? 8'h00 : k);
      end
      $display("test clock sources done");
      wr_reg(3'h2, 8'h28);
      wr_reg(3'h3, 8'h00);
      for (n = 0; n < 16; n++)
      begin
         wr_reg(3'h4, 8'h10);
         wr_reg(3'h5, {2'b00, 2'(n >> 2), n[1], n[0], 2'b01});
         wr_reg(3'h6, 8'h03);
         wr_reg(3'h4, 8'h18);
         repeat (3) @(posedge core_clk);
         `CHK({p0, p1, p2, drv}, {{3{n[1] ^ n[0]}}, 1'b1}, "initial level")
         wait_hi(0, 100);
         repeat (3) @(posedge core_clk);
         // level equal to initial leaves pin still
         e = n[3:2] == 0 ? n[1] : n[3:2] == 1 ? 1'b0 : n[3:2] == 2 ? 1'b1 : ~n[1];
         `CHK({p0, fp}, {e ^ n[0], 1'b0}, "match level")
      end
      $display("test compare output done");
      wr_reg(3'h4, 8'h10);
      wr_reg(3'h5, 8'hc0);
      wr_reg(3'h6, 8'h03);
      wr_reg(3'h4, 8'h19);
      wait_hi(1, 140);
      `CHK({i > 120, drv}, 2'b10, "period match")
      $display("test period match done");
      for (n = 0; n < 4; n++)
      begin
         wr_reg(3'h4, 8'h10);
         wr_reg(3'h5, {2'b01, 2'(n), 4'h0});
         wr_reg(3'h6, 8'h07);
         wr_reg(3'h4, 8'h18);
         burst(8'h02, 1'b0);
         `CHK({fc, drv}, {n != 3, 1'b0}, "capture flag")
      end
      $display("test capture done");
      wr_reg(3'h2, 8'hff);
      wr_reg(3'h3, 8'h03);
      for (n = 0; n < 12; n++)
      begin
         wr_reg(3'h4, 8'h10);
         wr_reg(3'h5, {2'b10, 2'(n >> 2), n[0], n[1], n[1], 1'b0});
         wr_reg(3'h4, 8'h19);
         repeat (5) @(posedge core_clk);
         e = (n < 4 ? ~n[0] : n[0]) ^ n[1];
         `CHK(p0, e, "forced or early level")
         repeat (150) @(posedge core_clk);
         e = (n < 4 || (n >= 8 && n[1]) ? ~n[0] : n[0]) ^ n[1];
         `CHK(p0, e, "late level")
      end
      $display("test pwm done");
      wr_reg(3'h4, 8'h10);
      wr_reg(3'h2, 8'h10);
      wr_reg(3'h3, 8'h00);
      wr_reg(3'h5, 8'hb8);
      wr_reg(3'h4, 8'h18);
      repeat (3) @(posedge core_clk);
      `CHK({p0, on_q}, 2'b11, "pulse start")
      repeat (30) @(posedge core_clk);
      `CHK({p0, on_q}, 2'b00, "pulse end")
      $display("test single pulse done");
      complete_run();
   end
endmodule
